// ===== rtl/usb_ep_pkg.sv
// constants for the endpoint configuration and control/status block
package usb_ep_pkg;
   // register byte offsets
   localparam logic [11:0]       EP1_CONFIG_OFF = 12'h038;
   localparam logic [11:0]       EP2_CONFIG_OFF = 12'h04C;
   localparam logic [11:0]       EP3_CONFIG_OFF = 12'h060;
   localparam logic [11:0]       EP4_CSR_OFF    = 12'h064;
   localparam logic [11:0]       EP5_CSR_OFF    = 12'h078;
   localparam logic [11:0]       EP6_CSR_OFF    = 12'h08C;
   localparam logic [11:0]       EP7_CSR_OFF    = 12'h0A0;
   localparam logic [2:0][11:0]  CFG_OFFS = {EP3_CONFIG_OFF, EP2_CONFIG_OFF, EP1_CONFIG_OFF};
   localparam logic [3:0][11:0]  CSR_OFFS = {EP7_CSR_OFF, EP6_CSR_OFF, EP5_CSR_OFF, EP4_CSR_OFF};
   localparam int                NUM_CFG  = 3;
   localparam int                NUM_CSR  = 4;
   // endpoint buffer ram window
   localparam logic [1:0]        RAM_SEL    = 2'h1;   // paddr[11:10] of the ram window
   localparam int                RAM_BYTES  = 1024;
   localparam int                RAM_WORDS  = RAM_BYTES / 4;
   localparam int                RAM_AW     = 8;
   // config register layout
   localparam logic [31:0]       CFG_RESET  = 32'h1000_03FF;
   localparam logic [31:0]       CFG_WMASK  = 32'h9F01_FFFF;
   localparam int                CFG_ON_BIT   = 31;
   localparam int                CFG_KIND_BIT = 29;
   localparam int                CFG_DIR_BIT  = 28;
   localparam int                CFG_NUM_LO   = 24;
   localparam int                CFG_LEN_LO   = 10;
   localparam int                CFG_OFF_LO   = 0;
   // control/status register layout
   localparam logic [7:0]        CSR_RESET    = 8'h02;
   localparam logic [7:0]        CSR_SW_MASK  = 8'h7F;
   localparam int                CSR_ENG_TGL  = 7;
   localparam int                CSR_CPU_TGL  = 6;
   localparam int                CSR_STALL_RX = 5;
   localparam int                CSR_NAK_RX   = 4;
   localparam int                CSR_DTG_RX   = 3;
   localparam int                CSR_STALL_TX = 2;
   localparam int                CSR_NAK_TX   = 1;
   localparam int                CSR_DTG_TX   = 0;
endpackage : usb_ep_pkg

// ===== rtl/ep_ram_if.sv
// two-port access bundle between the register block and the buffer ram
interface ep_ram_if;
   import usb_ep_pkg::*;
   logic [RAM_AW-1:0] a_addr;
   logic              a_we;
   logic [31:0]       a_wdata;
   logic [31:0]       a_rdata;
   logic [RAM_AW-1:0] b_addr;
   logic              b_we;
   logic [31:0]       b_wdata;
   logic [31:0]       b_rdata;
   modport owner (output a_addr, a_we, a_wdata, b_addr, b_we, b_wdata,
                  input a_rdata, b_rdata);
   modport mem   (input a_addr, a_we, a_wdata, b_addr, b_we, b_wdata,
                  output a_rdata, b_rdata);
endinterface : ep_ram_if

// ===== rtl/ep_buffer_ram.sv
// endpoint buffer ram, 1024 bytes, two synchronous ports
module ep_buffer_ram
   import usb_ep_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // ports
   ep_ram_if.mem     ram
);
   logic [31:0] mem_q [RAM_WORDS];   // 256 words of 4 bytes [RULE_09]
   logic [31:0] a_rdata_q;
   logic [31:0] b_rdata_q;

   // storage; port a (software) wins a same-word collision
   always_ff @(posedge clk) begin
      if (ram.b_we && !(ram.a_we && ram.a_addr == ram.b_addr)) begin
         mem_q[ram.b_addr] <= ram.b_wdata;
      end
      if (ram.a_we) begin
         mem_q[ram.a_addr] <= ram.a_wdata;
      end
   end

   // registered read data on both ports
   always_ff @(posedge clk) begin
      if (reset) begin
         a_rdata_q <= 32'h0000_0000;
         b_rdata_q <= 32'h0000_0000;
      end else begin
         a_rdata_q <= mem_q[ram.a_addr];
         b_rdata_q <= mem_q[ram.b_addr];
      end
   end

   assign ram.a_rdata = a_rdata_q;
   assign ram.b_rdata = b_rdata_q;
endmodule : ep_buffer_ram

// ===== rtl/usb_ep_regs.sv
// endpoint configuration and control/status registers with buffer ram
// How it works
// RULE_01 - endpoint top bit off disables the endpoint, on enables it
// RULE_02 - transfer kind bit of endpoints one to three always reads zero
// RULE_03 - direction bit zero means OUT, one means IN
// RULE_04 - software sets a nonzero endpoint number; zero disables the endpoint
// RULE_05 - software writes packet length only as a multiple of four bytes
// RULE_06 - software never programs a packet length above 64 bytes
// RULE_07 - zero packet length disables the endpoint
// RULE_08 - software keeps buffer offset word aligned between 0x008 and 0x3FC
// RULE_09 - a 1024 byte buffer ram, offsets are byte offsets into it
// RULE_10 - endpoints four to seven hold eight control/status bits in the low byte
// RULE_11 - receive toggle inverts after a good packet is accepted and acked
// RULE_12 - writing one inverts stall, nak and toggle bits; zero leaves them
// RULE_13 - engine toggle inverts per finished buffer; nak until cpu toggle catches up (the code naks while engine and cpu toggles are equal)
// RULE_14 - reserved bits read zero and ignore writes
//
// Our own choice: the APB register port.
module usb_ep_regs
   import usb_ep_pkg::*;
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // serial engine events for endpoints four to seven, one-cycle pulses
   input  wire logic [3:0]    rx_accept,
   input  wire logic [3:0]    tx_accept,
   input  wire logic [3:0]    buffer_done,
   input  wire logic [3:0]    rx_nak_set,
   // serial engine buffer ram port
   input  wire logic [7:0]    eng_addr,
   input  wire logic          eng_we,
   input  wire logic [31:0]   eng_wdata,
   output logic      [31:0]   eng_rdata,
   // endpoint one to three settings
   output logic      [2:0]    ep_enabled,
   output logic      [2:0]    ep_direction_in,
   output logic      [11:0]   ep_number,
   output logic      [20:0]   ep_packet_len,
   output logic      [29:0]   ep_buf_offset,
   // endpoint four to seven state
   output logic      [31:0]   ep_ctrl_status,
   output logic      [3:0]    ep_dbuf_nak
);
   // register state
   logic [NUM_CFG-1:0][31:0] cfg_q;
   logic [NUM_CFG-1:0][31:0] cfg_d;
   logic [NUM_CSR-1:0][7:0]  csr_q;
   logic [NUM_CSR-1:0][7:0]  csr_d;
   logic [2:0]               enabled_q;
   logic [3:0]               dbuf_nak_q;
   // bus state
   logic                     pready_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;
   logic                     wr_done;
   logic                     rd_setup;
   logic                     ram_hit;
   logic [31:0]              rd_data;
   logic                     rd_hit;

   ep_ram_if ram ();

   ep_buffer_ram u_ram (
      .clk   (clk),
      .reset (reset),
      .ram   (ram)
   );

   // write takes effect at the edge where pready is seen high
   assign wr_done  = psel && penable && pready_q && pwrite;
   assign rd_setup = psel && penable && !pready_q;
   assign ram_hit  = (paddr[11:10] == RAM_SEL) && (paddr[1:0] == 2'h0);

   // software and engine ports of the buffer ram
   assign ram.a_addr  = paddr[9:2];                     // byte offset to word [RULE_09]
   assign ram.a_we    = wr_done && ram_hit;
   assign ram.a_wdata = pwdata;
   assign ram.b_addr  = eng_addr;
   assign ram.b_we    = eng_we;
   assign ram.b_wdata = eng_wdata;

   // next state of every configuration and control/status register
   for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      logic hit;
      assign hit = wr_done && (paddr == CFG_OFFS[i]);
      // kind and reserved bits stay zero through the write mask
      assign cfg_d[i] = hit ? (pwdata & CFG_WMASK) : cfg_q[i]; // [RULE_02] [RULE_14]
   end

   for (genvar i = 0; i < NUM_CSR; i++) begin : g_csr
      logic       hit;
      logic [7:0] flip;
      logic [7:0] nxt;
      assign hit  = wr_done && (paddr == CSR_OFFS[i]);
      // software toggles on written ones, engine toggle is hardware only
      assign flip = hit ? (pwdata[7:0] & CSR_SW_MASK) : 8'h00;            // [RULE_12]
      always_comb begin
         nxt              = csr_q[i] ^ flip;                            // [RULE_10]
         nxt[CSR_DTG_RX]  = nxt[CSR_DTG_RX] ^ rx_accept[i];             // [RULE_11]
         nxt[CSR_DTG_TX]  = nxt[CSR_DTG_TX] ^ tx_accept[i];
         nxt[CSR_ENG_TGL] = nxt[CSR_ENG_TGL] ^ buffer_done[i];          // [RULE_13]
         nxt[CSR_NAK_RX]  = nxt[CSR_NAK_RX] | rx_nak_set[i];            // set wins
      end
      assign csr_d[i] = nxt;
   end

   // register update
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= {NUM_CFG{CFG_RESET}};
         csr_q <= {NUM_CSR{CSR_RESET}};
      end else begin
         cfg_q <= cfg_d;
         csr_q <= csr_d;
      end
   end

   // derived endpoint state, registered
   always_ff @(posedge clk) begin
      if (reset) begin
         enabled_q  <= 3'h0;
         dbuf_nak_q <= 4'h0;
      end else begin
         for (int i = 0; i < NUM_CFG; i++) begin
            enabled_q[i] <= cfg_q[i][CFG_ON_BIT]                              // [RULE_01]
                            && (cfg_q[i][CFG_NUM_LO +: 4] != 4'h0)            // [RULE_04]
                            && (cfg_q[i][CFG_LEN_LO +: 7] != 7'h00);          // [RULE_07]
         end
         for (int i = 0; i < NUM_CSR; i++) begin
            // engine has caught up with the cpu: no buffer ready
            dbuf_nak_q[i] <= csr_q[i][CSR_ENG_TGL] == csr_q[i][CSR_CPU_TGL]; // [RULE_13]
         end
      end
   end

   // read mux and decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b0;
      for (int i = 0; i < NUM_CFG; i++) begin
         if (paddr == CFG_OFFS[i]) begin
            rd_data = cfg_q[i];
            rd_hit  = 1'b1;
         end
      end
      for (int i = 0; i < NUM_CSR; i++) begin
         if (paddr == CSR_OFFS[i]) begin
            rd_data = {24'h00_0000, csr_q[i]};                  // [RULE_14]
            rd_hit  = 1'b1;
         end
      end
      if (ram_hit) begin
         rd_data = ram.a_rdata;
         rd_hit  = 1'b1;
      end
   end

   // apb answer: one wait state, then pready for one cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= rd_setup;
         if (rd_setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_q <= !rd_hit;                               // unmapped address
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // outputs
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign eng_rdata = ram.b_rdata;
   assign ep_enabled  = enabled_q;
   assign ep_dbuf_nak = dbuf_nak_q;
   for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg_out
      assign ep_direction_in[i]     = cfg_q[i][CFG_DIR_BIT];   // 1 = IN [RULE_03]
      assign ep_number[i*4 +: 4]    = cfg_q[i][CFG_NUM_LO +: 4];
      assign ep_packet_len[i*7 +: 7] = cfg_q[i][CFG_LEN_LO +: 7];
      assign ep_buf_offset[i*10 +: 10] = cfg_q[i][CFG_OFF_LO +: 10];
   end
   for (genvar i = 0; i < NUM_CSR; i++) begin : g_csr_out
      assign ep_ctrl_status[i*8 +: 8] = csr_q[i];
   end

   // checks per configuration register
   for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg_chk
      AST_KIND_ZERO: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
         !cfg_q[i][CFG_KIND_BIT])
         else $error("transfer kind bit not zero");
      AST_ON_OFF: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
         !cfg_q[i][CFG_ON_BIT] |=> !ep_enabled[i])
         else $error("endpoint enabled while its enable bit is clear");
      AST_NUM_ZERO: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
         cfg_q[i][CFG_NUM_LO +: 4] == 4'h0 |=> !ep_enabled[i])
         else $error("endpoint enabled with number zero");
      AST_LEN_ZERO: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
         cfg_q[i][CFG_LEN_LO +: 7] == 7'h00 |=> !ep_enabled[i])
         else $error("endpoint enabled with zero packet length");
      AST_FULL_ON: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
         cfg_q[i][CFG_ON_BIT] && cfg_q[i][CFG_NUM_LO +: 4] != 4'h0
         && cfg_q[i][CFG_LEN_LO +: 7] != 7'h00 |=> ep_enabled[i])
         else $error("configured endpoint not enabled");
      AST_DIR_WRITE: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
         wr_done && paddr == CFG_OFFS[i] |=> ep_direction_in[i] == $past(pwdata[CFG_DIR_BIT]))
         else $error("direction bit does not follow the write");
      AST_CFG_RSVD: assert property (@(posedge clk) disable iff (reset) // [RULE_14]
         cfg_q[i][30] == 1'b0 && cfg_q[i][23:17] == 7'h00)
         else $error("reserved config bits not zero");
   end

   // checks per control/status register
   for (genvar i = 0; i < NUM_CSR; i++) begin : g_csr_chk
      AST_RX_TOGGLE: assert property (@(posedge clk) disable iff (reset) // [RULE_11]
         rx_accept[i] && !(wr_done && paddr == CSR_OFFS[i])
         |=> csr_q[i][CSR_DTG_RX] != $past(csr_q[i][CSR_DTG_RX]))
         else $error("receive toggle not inverted after accepted packet");
      AST_SW_STALL: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
         wr_done && paddr == CSR_OFFS[i]
         |=> csr_q[i][CSR_STALL_RX] == ($past(csr_q[i][CSR_STALL_RX]) ^ $past(pwdata[CSR_STALL_RX])))
         else $error("stall bit does not toggle on written one only");
      AST_ENG_TOGGLE: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
         buffer_done[i] |=> csr_q[i][CSR_ENG_TGL] != $past(csr_q[i][CSR_ENG_TGL]))
         else $error("engine buffer toggle not inverted");
      AST_DBUF_NAK: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
         csr_q[i][CSR_ENG_TGL] == csr_q[i][CSR_CPU_TGL] |=> ep_dbuf_nak[i])
         else $error("no nak while no buffer is ready");
   end

   // bus answer timing
   AST_PREADY: assert property (@(posedge clk) disable iff (reset)
      psel && penable && !pready |=> pready)
      else $error("pready not raised one cycle into the access phase");
   AST_PREADY_ONE: assert property (@(posedge clk) disable iff (reset)
      pready |=> !pready)
      else $error("pready held for more than one cycle");
   AST_RSVD_READ: assert property (@(posedge clk) disable iff (reset) // [RULE_14]
      rd_setup && !pwrite && paddr == EP4_CSR_OFF |=> prdata[31:8] == 24'h00_0000)
      else $error("reserved control/status bits read nonzero");
endmodule : usb_ep_regs

// ===== dv/engine_model.sv
// serial engine stand-in: event pulses and the buffer ram port
module engine_model (
   // clock
   input  wire logic        clk,
   // event pulses, bit0 = endpoint four
   output logic      [3:0]  rx_accept,
   output logic      [3:0]  tx_accept,
   output logic      [3:0]  buffer_done,
   output logic      [3:0]  rx_nak_set,
   // buffer ram port
   output logic      [7:0]  eng_addr,
   output logic             eng_we,
   output logic      [31:0] eng_wdata,
   input  wire logic [31:0] eng_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0][3:0] ev;

   // event vector split into the four pulse kinds
   assign rx_accept   = ev[0];
   assign tx_accept   = ev[1];
   assign buffer_done = ev[2];
   assign rx_nak_set  = ev[3];

   // idle values at time zero
   initial begin
      ev        = '0;
      eng_addr  = 8'h00;
      eng_we    = 1'b0;
      eng_wdata = 32'h0;
   end

   // one-cycle pulse of one event kind on one endpoint
   task automatic pulse(input int kind, input int ep);
      @(posedge clk);
      ev[kind][ep] <= 1'b1;
      @(posedge clk);
      ev <= '0;
   endtask : pulse

   // single word write, data bus inverted once released
   task automatic ram_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      eng_addr  <= a;
      eng_we    <= 1'b1;
      eng_wdata <= d;
      @(posedge clk);
      eng_we    <= 1'b0;
      eng_wdata <= ~d;
   endtask : ram_wr

   // read data arrives one edge after the address is taken
   task automatic ram_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      eng_addr <= a;
      repeat (2) @(posedge clk);
      d = eng_rdata;
   endtask : ram_rd
endmodule : engine_model

// ===== dv/usb_endpoint_config_regs_tb_top.sv
// self-checking bench for the endpoint configuration register block
module usb_endpoint_config_regs_tb_top import usb_ep_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, eng_we;
   logic [11:0] paddr, ep_number;
   logic [31:0] pwdata, prdata, eng_wdata, eng_rdata, ep_ctrl_status;
   logic [3:0]  rx_accept, tx_accept, buffer_done, rx_nak_set, ep_dbuf_nak;
   logic [7:0]  eng_addr;
   logic [2:0]  ep_enabled, ep_direction_in;
   logic [20:0] ep_packet_len;
   logic [29:0] ep_buf_offset;
   int          errors, tests_run;

   usb_ep_regs u_usb_ep_regs (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rx_accept, .tx_accept, .buffer_done, .rx_nak_set,
      .eng_addr, .eng_we, .eng_wdata, .eng_rdata, .ep_enabled, .ep_direction_in,
      .ep_number, .ep_packet_len, .ep_buf_offset, .ep_ctrl_status, .ep_dbuf_nak);
   engine_model u_engine_model (.clk, .rx_accept, .tx_accept, .buffer_done,
      .rx_nak_set, .eng_addr, .eng_we, .eng_wdata, .eng_rdata);

   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk(32'(n < 20), 32'h1);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk(32'(e), 32'h0);
   endtask : rd_chk

   // let registered outputs follow
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   task automatic reset_test;
      for (int i = 0; i < 3; i++) rd_chk(CFG_OFFS[i], CFG_RESET);
      for (int i = 0; i < 4; i++) rd_chk(CSR_OFFS[i], 32'(CSR_RESET));
      chk(32'(ep_enabled), 32'h0);
      chk(32'(ep_dbuf_nak), 32'hF);
   endtask : reset_test

   // unmapped and unaligned places are refused
   task automatic map_test;
      logic [31:0] r;
      logic        e;
      apb(1'b0, 12'h03C, 32'h0, r, e);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 12'h039, 32'h0, r, e);
      chk(32'(e), 32'h1);
      rd_chk(EP1_CONFIG_OFF, CFG_RESET);
   endtask : map_test

   task automatic cfg_test;
      logic [3:0][31:0] m;
      logic [31:0]      v;
      m = {32'h6FFF_FFFF, 32'hFFFE_03FF, 32'hF0FF_FFFF, 32'hFFFF_FFFF};
      for (int i = 0; i < 3; i++) begin
         wr(CFG_OFFS[i], 32'hFFFF_FFFF);
         rd_chk(CFG_OFFS[i], 32'h9F01_FFFF);
         // legal length and offset only
         v = {1'b1, 2'b00, 1'b1, 4'(i + 5), 7'h00, 7'd64, 10'h3FC - 10'(4 * i)};
         for (int k = 0; k < 4; k++) begin
            wr(CFG_OFFS[i], v & m[k]);
            rd_chk(CFG_OFFS[i], v & m[k]);
            settle();
            chk(32'(ep_enabled[i]), 32'(k == 0));
            chk(32'(ep_direction_in[i]), 32'(m[k][28]));
            if (k == 0) begin
               chk(32'(ep_number[4*i+:4]), 32'(i + 5));
               chk(32'(ep_packet_len[7*i+:7]), 32'd64);
               chk(32'(ep_buf_offset[10*i+:10]), 32'(v[9:0]));
            end
         end
      end
   endtask : cfg_test

   // software writes then engine events on each status register
   task automatic csr_test;
      logic [3:0][31:0] wd;
      logic [7:0][7:0]  ex;
      logic [3:0][1:0]  evk;
      wd  = {32'h3F, 32'h40, 32'h80, 32'hFFFF_FF3F};
      ex  = {8'hDB, 8'hCB, 8'hCA, 8'hC2, 8'h42, 8'h7D, 8'h3D, 8'h3D};
      evk = {2'd3, 2'd1, 2'd0, 2'd2};
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 8; s++) begin
            if (s < 4) wr(CSR_OFFS[i], wd[s]);
            else u_engine_model.pulse(int'(evk[s-4]), i);
            settle();
            chk(32'(ep_ctrl_status[8*i+:8]), 32'(ex[s]));
            chk(32'(ep_dbuf_nak[i]), 32'(ex[s][7] == ex[s][6]));
         end
         rd_chk(CSR_OFFS[i], 32'(ex[7]));
      end
   endtask : csr_test

   task automatic ram_test;
      logic [31:0] d;
      wr(12'h408, 32'hA5C3_0F96);
      u_engine_model.ram_rd(8'h02, d);
      chk(d, 32'hA5C3_0F96);
      u_engine_model.ram_wr(8'hFF, 32'h1234_5678);
      rd_chk(12'h7FC, 32'h1234_5678);
   endtask : ram_test

   // main sequence
   initial begin
      reset   = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      errors    = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      reset_test();
      map_test();
      cfg_test();
      csr_test();
      ram_test();
      wrap_up();
   end

   // watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
endmodule : usb_endpoint_config_regs_tb_top
